// ---- rtl/gptf_pkg.sv ----
// Purpose: Shared constants for the general purpose timer family.
// Assumes: One peripheral clock, synchronous active-high reset.
// Notes:   Variant selection and channel modes are enumerated here.
package gptf_pkg;

    // Timer variants built from the one parameterised core.
    localparam logic [1:0] GPTF_VAR_WIDE     = 2'h0;
    localparam logic [1:0] GPTF_VAR_STANDARD = 2'h1;
    localparam logic [1:0] GPTF_VAR_REDUCED  = 2'h2;
    localparam logic [1:0] GPTF_VAR_BASIC    = 2'h3;

    // Counter and prescaler widths.
    localparam int GPTF_WIDE_CNT_W = 32;
    localparam int GPTF_STD_CNT_W  = 16;
    localparam int GPTF_PSC_W      = 16;
    localparam int GPTF_MAX_CH     = 4;

    // Channel modes.
    localparam logic [1:0] GPTF_CH_CAPTURE = 2'h0;
    localparam logic [1:0] GPTF_CH_COMPARE = 2'h1;
    localparam logic [1:0] GPTF_CH_PWM     = 2'h2;
    localparam logic [1:0] GPTF_CH_ONEPULS = 2'h3;

    // Counter slave modes.
    localparam logic [1:0] GPTF_SM_FREE    = 2'h0;
    localparam logic [1:0] GPTF_SM_RESET   = 2'h1;
    localparam logic [1:0] GPTF_SM_GATED   = 2'h2;
    localparam logic [1:0] GPTF_SM_ENCODER = 2'h3;

    // Reset values.
    localparam logic [1:0] GPTF_RST_OUT = 2'h0;

endpackage : gptf_pkg

// ---- rtl/gptf_sync2.sv ----
// Purpose: Two-flop synchroniser for a bus of pin inputs.
// Assumes: Inputs are asynchronous to i_mclk.
// Notes:   The first stage is read only by the second stage.
module gptf_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_srst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } gptf_sync_s;

    gptf_sync_s state_ff;
    gptf_sync_s nxt_state;

    // Shift the pins through two stages.
    always_comb begin
        nxt_state.meta = i_async;
        nxt_state.sync = state_ff.meta;
    end

    // Both stages clear on reset so no unknown reaches the core.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_sync = state_ff.sync;

endmodule // gptf_sync2

// ---- rtl/gptf_timer.sv ----
// Purpose: One general purpose timer of the family, variant by parameter.
// Assumes: Configuration inputs are static or from i_mclk logic.
// Notes:   Pins (channels, encoder, halls) are synchronised first.
// Operation
// - Wide variant: 32-bit up/down, 16-bit prescaler.
// - Standard variant: 16-bit up/down, 16-bit prescaler.
// - Full variants have four configurable channels.
// - Exchange triggers with peer timers.
// - Debug halt freezes the counter of full variants when enabled; reduced and basic variants keep counting.
// - Own DMA requests per timer.
// - Quadrature decode and one-to-four hall inputs.
// - Reduced variants count upward only.
// - Reduced variants have one or two channels.
// - Reduced variants follow full timer triggers.
// - Reduced usable as plain time base.
// - Basic time base triggers converter.
module gptf_timer #(
    parameter logic [1:0] VARIANT = gptf_pkg::GPTF_VAR_WIDE,
    parameter int         CNT_W   = gptf_pkg::GPTF_WIDE_CNT_W,
    parameter int         NCH     = gptf_pkg::GPTF_MAX_CH
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_srst,
    input  wire logic                  i_enable,
    input  wire logic                  i_dir_down,
    input  wire logic [1:0]            i_slave_mode,
    input  wire logic                  i_dbg_halt,
    input  wire logic                  i_dbg_freeze_en,
    input  wire logic [15:0]           i_psc,
    input  wire logic [CNT_W-1:0]      i_arr,
    input  wire logic [2*NCH-1:0]      i_ch_mode,
    input  wire logic [NCH*CNT_W-1:0]  i_ch_cmp,
    input  wire logic [NCH-1:0]        i_ch_flag_clr,
    input  wire logic [NCH-1:0]        i_ch_pin,
    input  wire logic [1:0]            i_enc_ab,
    input  wire logic [3:0]            i_hall,
    input  wire logic                  i_trig_in,
    output logic                       o_trig_out,
    output logic [CNT_W-1:0]           o_count,
    output logic                       o_update,
    output logic                       o_dma_req,
    output logic                       o_conv_trig,
    output logic [NCH-1:0]             o_ch_out,
    output logic [NCH-1:0]             o_ch_flag,
    output logic [NCH*CNT_W-1:0]       o_ch_capt,
    output logic                       o_hall_evt
);

    localparam bit FULL = (VARIANT == gptf_pkg::GPTF_VAR_WIDE) ||
                          (VARIANT == gptf_pkg::GPTF_VAR_STANDARD);
    localparam int PW   = gptf_pkg::GPTF_PSC_W;

    typedef struct packed {
        logic [PW-1:0]          psc_cnt;
        logic [CNT_W-1:0]       cnt;
        logic                   update;
        logic                   dma;
        logic                   conv;
        logic                   trig_out;
        logic [NCH-1:0]         ch_out;
        logic [NCH-1:0]         ch_flag;
        logic [NCH-1:0]         pin_d;
        logic [NCH-1:0]         pulse_done;
        logic [NCH*CNT_W-1:0]   capt;
        logic [1:0]             enc_d;
        logic [3:0]             hall_d;
        logic                   trig_d;
        logic                   hall_evt;
    } gptf_state_s;

    gptf_state_s state_ff;
    gptf_state_s nxt_state;

    logic [NCH-1:0] pin_s;
    logic [1:0]     enc_s;
    logic [3:0]     hall_s;
    logic           trig_s;

    // Peer triggers come from other logic but may cross domains in a
    // larger system, so they are synchronised with the pins.
    gptf_sync2 #(
        .W (NCH + 7)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_async ({i_ch_pin, i_enc_ab, i_hall, i_trig_in}),
        .o_sync  ({pin_s, enc_s, hall_s, trig_s})
    );

    logic           trig_rise;
    logic           frozen;
    logic           run;
    logic           tick;
    logic           down;
    logic           enc_step;
    logic           enc_down;
    logic           wrap;
    logic [CNT_W-1:0] cnt_step;

    always_comb begin
        trig_rise = trig_s && !state_ff.trig_d;
        frozen = FULL && i_dbg_halt && i_dbg_freeze_en;
        run = i_enable && !frozen &&
              !(i_slave_mode == gptf_pkg::GPTF_SM_GATED && !trig_s);
        enc_step = FULL && (enc_s != state_ff.enc_d) &&
                   (i_slave_mode == gptf_pkg::GPTF_SM_ENCODER);
        enc_down = enc_s[0] ^ state_ff.enc_d[1];
        down = FULL && ((i_slave_mode == gptf_pkg::GPTF_SM_ENCODER)
                        ? enc_down : i_dir_down);
        tick = (i_slave_mode == gptf_pkg::GPTF_SM_ENCODER) ? enc_step :
               (state_ff.psc_cnt == i_psc);
        wrap = down ? (state_ff.cnt == '0) : (state_ff.cnt >= i_arr);
        cnt_step = down ? state_ff.cnt - 1'b1 : state_ff.cnt + 1'b1;
    end

    // Next-state logic for counter, channels and event outputs.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.update   = 1'b0;
        nxt_state.dma      = 1'b0;
        nxt_state.conv     = 1'b0;
        nxt_state.trig_out = 1'b0;
        nxt_state.hall_evt = 1'b0;
        nxt_state.pin_d    = pin_s;
        nxt_state.enc_d    = enc_s;
        nxt_state.hall_d   = hall_s;
        nxt_state.trig_d   = trig_s;
        if (run) begin
            nxt_state.psc_cnt = (state_ff.psc_cnt == i_psc) ? '0 :
                                state_ff.psc_cnt + 1'b1;
            if (tick) begin
                if (wrap) begin
                    nxt_state.cnt      = down ? i_arr : '0;
                    nxt_state.update   = 1'b1;
                    nxt_state.dma      = 1'b1;
                    nxt_state.conv     = 1'b1;
                    nxt_state.trig_out = 1'b1;
                    nxt_state.pulse_done = '1;
                end else begin
                    nxt_state.cnt = cnt_step;
                end
            end
        end
        if (i_slave_mode == gptf_pkg::GPTF_SM_RESET && trig_rise) begin
            nxt_state.cnt     = '0;
            nxt_state.psc_cnt = '0;
            nxt_state.pulse_done = '0;
        end
        if (FULL && hall_s != state_ff.hall_d) begin
            nxt_state.hall_evt = 1'b1;
            if (i_slave_mode == gptf_pkg::GPTF_SM_RESET) begin
                nxt_state.cnt = '0;
            end
        end
        for (int c = 0; c < NCH; c++) begin
            logic [CNT_W-1:0] cmp;
            logic             hit;
            cmp = i_ch_cmp[c*CNT_W +: CNT_W];
            hit = 1'b0;
            if (i_ch_flag_clr[c]) begin
                nxt_state.ch_flag[c] = 1'b0;
            end
            case (i_ch_mode[2*c +: 2])
                gptf_pkg::GPTF_CH_CAPTURE: begin
                    if (pin_s[c] && !state_ff.pin_d[c]) begin
                        nxt_state.capt[c*CNT_W +: CNT_W] = state_ff.cnt;
                        hit = 1'b1;
                    end
                    nxt_state.ch_out[c] = 1'b0;
                end
                gptf_pkg::GPTF_CH_COMPARE: begin
                    if (tick && run && state_ff.cnt == cmp) begin
                        nxt_state.ch_out[c] = !state_ff.ch_out[c];
                        hit = 1'b1;
                    end
                end
                gptf_pkg::GPTF_CH_PWM: begin
                    nxt_state.ch_out[c] = (state_ff.cnt < cmp);
                    hit = run && tick && (state_ff.cnt == cmp);
                end
                default: begin
                    // One pulse: high until match, then held low.
                    nxt_state.ch_out[c] = !state_ff.pulse_done[c] &&
                                          (state_ff.cnt < cmp);
                    if (run && tick && state_ff.cnt == cmp) begin
                        nxt_state.pulse_done[c] = 1'b1;
                        hit = 1'b1;
                    end
                end
            endcase
            // Set wins over a clear in the same cycle.
            if (hit) begin
                nxt_state.ch_flag[c] = 1'b1;
                nxt_state.dma        = 1'b1;
            end
        end
        if (!FULL) begin
            nxt_state.hall_evt = 1'b0;
        end
        if (VARIANT == gptf_pkg::GPTF_VAR_BASIC) begin
            nxt_state.ch_out  = '0;
            nxt_state.ch_flag = '0;
        end
    end

    // State register.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_count     = state_ff.cnt;
    assign o_update    = state_ff.update;
    assign o_dma_req   = state_ff.dma;
    assign o_conv_trig = state_ff.conv;
    assign o_trig_out  = state_ff.trig_out;
    assign o_ch_out    = state_ff.ch_out;
    assign o_ch_flag   = state_ff.ch_flag;
    assign o_ch_capt   = state_ff.capt;
    assign o_hall_evt  = state_ff.hall_evt;

    // Checks sit next to the logic they guard.
    a_freeze_hold: assert property (@(posedge i_mclk) disable iff (i_srst)
        frozen && $past(frozen) |-> $stable(o_count))
        else $error("Counter moved while frozen.");
    a_update_pair: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_update |-> o_dma_req && o_trig_out)
        else $error("Update without DMA or trigger.");
    a_conv_trig: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_update == o_conv_trig)
        else $error("Converter trigger mismatch.");
    a_reduced_up: assert property (@(posedge i_mclk) disable iff (i_srst)
        !FULL && !o_update && $past(run) && $past(tick) &&
        !$past(trig_rise) &&
        !$past(i_srst) |-> o_count == $past(o_count) + 1'b1)
        else $error("Reduced timer did not count up.");
    a_reload_up: assert property (@(posedge i_mclk) disable iff (i_srst)
        run && tick && wrap && !down && !trig_rise &&
        hall_s == state_ff.hall_d |=> o_count == '0 && o_update)
        else $error("Up reload failed.");
    a_reload_dn: assert property (@(posedge i_mclk) disable iff (i_srst)
        run && tick && wrap && down && !trig_rise &&
        hall_s == state_ff.hall_d |=> o_count == $past(i_arr))
        else $error("Down reload failed.");
    a_capt_flag: assert property (@(posedge i_mclk) disable iff (i_srst)
        i_ch_mode[1:0] == gptf_pkg::GPTF_CH_CAPTURE && pin_s[0] &&
        !state_ff.pin_d[0] |=> o_ch_flag[0] &&
        o_ch_capt[CNT_W-1:0] == $past(o_count))
        else $error("Capture not latched.");
    a_hall_evt: assert property (@(posedge i_mclk) disable iff (i_srst)
        FULL && hall_s != state_ff.hall_d |=> o_hall_evt)
        else $error("Hall change missed.");
    c_update: cover property (@(posedge i_mclk) o_update);
    c_capture: cover property (@(posedge i_mclk) o_ch_flag[0]);
    c_frozen: cover property (@(posedge i_mclk) frozen);
    c_encoder: cover property (@(posedge i_mclk) enc_step);

endmodule // gptf_timer

// ---- test/gptf_pins_model.sv ----
// Purpose: Model of pins, sensors and peer timer around the timer.
// Assumes: Called from the bench; every change lands at a falling edge.
// Notes:   Each change is held long enough for the two-flop sync.
module gptf_pins_model (
    input  wire logic       i_mclk,
    output logic      [3:0] o_ch_pin,
    output logic      [1:0] o_enc_ab,
    output logic      [3:0] o_hall,
    output logic            o_trig_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins and sensors idle low.
    initial begin
        o_ch_pin  = 4'h0;
        o_enc_ab  = 2'h0;
        o_hall    = 4'h0;
        o_trig_in = 1'b0;
    end
    task automatic trig_pulse();
        @(negedge i_mclk);
        o_trig_in = 1'b1;
        repeat (3) @(negedge i_mclk);
        o_trig_in = 1'b0;
    endtask
    task automatic pin_rise(input int c);
        @(negedge i_mclk);
        o_ch_pin[c] = 1'b1;
        repeat (5) @(negedge i_mclk);
        o_ch_pin[c] = 1'b0;
    endtask
    task automatic enc_step(input logic fwd);
        @(negedge i_mclk);
        o_enc_ab = fwd ? {~o_enc_ab[0], o_enc_ab[1]}
                       : {o_enc_ab[0], ~o_enc_ab[1]};
        repeat (3) @(negedge i_mclk);
    endtask
    task automatic hall_flip();
        @(negedge i_mclk);
        o_hall = o_hall ^ 4'h1;
    endtask
endmodule // gptf_pins_model

// ---- test/general_purpose_timer_family_tb.sv ----
// Purpose: Self-checking bench for the general purpose timer family.
// Assumes: Wide and reduced variants share stimulus and pins.
// Notes:   Inputs change at the falling edge and outputs are read there.
module general_purpose_timer_family_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_mclk, i_srst, en, dn, halt, frz;
    logic [1:0]   sm, ab;
    logic [15:0]  psc, r_cnt;
    logic [31:0]  arr, w_cnt, s;
    logic [7:0]   mode;
    logic [127:0] cmp, w_capt;
    logic [3:0]   fclr, pin, hall, w_out, w_flag;
    logic         trg, w_trg, w_upd, w_dma, w_conv, w_hev, r_upd;
    int           failures, comparisons, cycles, n;

    gptf_pins_model gptf_pins_model_inst (.i_mclk(i_mclk), .o_ch_pin(pin),
        .o_enc_ab(ab), .o_hall(hall), .o_trig_in(trg));
    gptf_timer #(.VARIANT(gptf_pkg::GPTF_VAR_WIDE)) gptf_timer_inst (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_enable(en), .i_dir_down(dn),
        .i_slave_mode(sm), .i_dbg_halt(halt), .i_dbg_freeze_en(frz),
        .i_psc(psc), .i_arr(arr), .i_ch_mode(mode), .i_ch_cmp(cmp),
        .i_ch_flag_clr(fclr), .i_ch_pin(pin), .i_enc_ab(ab), .i_hall(hall),
        .i_trig_in(trg), .o_trig_out(w_trg), .o_count(w_cnt),
        .o_update(w_upd), .o_dma_req(w_dma), .o_conv_trig(w_conv),
        .o_ch_out(w_out), .o_ch_flag(w_flag), .o_ch_capt(w_capt),
        .o_hall_evt(w_hev));
    // The reduced copy must ignore down and freeze settings; encoder mode stops its counter.
    gptf_timer #(.VARIANT(gptf_pkg::GPTF_VAR_REDUCED), .CNT_W(16),
        .NCH(1)) gptf_timer_red_inst (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_enable(en), .i_dir_down(dn),
        .i_slave_mode(sm), .i_dbg_halt(halt), .i_dbg_freeze_en(frz),
        .i_psc(psc), .i_arr(arr[15:0]), .i_ch_mode(mode[1:0]),
        .i_ch_cmp(cmp[15:0]), .i_ch_flag_clr(fclr[0]), .i_ch_pin(pin[0]),
        .i_enc_ab(ab), .i_hall(hall), .i_trig_in(trg), .o_trig_out(),
        .o_count(r_cnt), .o_update(r_upd), .o_dma_req(), .o_conv_trig(),
        .o_ch_out(), .o_ch_flag(), .o_ch_capt(), .o_hall_evt());

    // Free-running clock.
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Cut a hang short; the whole run needs far fewer cycles.
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Bounded wait for an update pulse of either copy.
    task automatic wait_upd(input bit red);
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while ((red ? r_upd : w_upd) !== 1'b1 && n < 200);
        chk("upd_seen", 32'h1, {31'h0, red ? r_upd : w_upd});
    endtask
    // Reset for one edge with a fresh configuration, then run.
    task automatic cfg(input logic [15:0] p, input logic [31:0] a,
                       input logic d, input logic [1:0] m);
        @(negedge i_mclk);
        i_srst = 1'b1;
        psc = p;
        arr = a;
        dn = d;
        sm = m;
        en = 1'b1;
        @(negedge i_mclk);
        i_srst = 1'b0;
    endtask
    task automatic t_period(input logic [15:0] p, input logic [31:0] a,
                            input logic d);
        cfg(p, a, d, gptf_pkg::GPTF_SM_FREE);
        wait_upd(1'b0);
        chk("reload", d ? a : 32'h0, w_cnt);
        chk("events", 32'h7, {w_dma, w_conv, w_trg});
        wait_upd(1'b0);
        chk("period", (a + 1) * (p + 1), n);
        wait_upd(1'b1);
        chk("red_reload", 32'h0, {16'h0, r_cnt});
    endtask
    task automatic t_freeze();
        cfg(16'h0, 32'h3E8, 1'b0, gptf_pkg::GPTF_SM_FREE);
        halt = 1'b1;
        frz = 1'b1;
        repeat (3) @(negedge i_mclk);
        s = w_cnt;
        n = r_cnt;
        repeat (10) @(negedge i_mclk);
        chk("frozen", s, w_cnt);
        chk("red_runs", 32'h1, {31'h0, r_cnt != n[15:0]});
        halt = 1'b0;
        repeat (4) @(negedge i_mclk);
        chk("resumed", 32'h1, {31'h0, w_cnt != s});
        frz = 1'b0;
    endtask
    task automatic t_capture();
        mode = 8'h00;
        cfg(16'h0, 32'h3E8, 1'b0, gptf_pkg::GPTF_SM_FREE);
        repeat (20) @(negedge i_mclk);
        en = 1'b0;
        @(negedge i_mclk);
        s = w_cnt;
        gptf_pins_model_inst.pin_rise(1);
        chk("flags", 32'h2, {28'h0, w_flag});
        chk("capture", s, w_capt[63:32]);
        fclr = 4'h2;
        @(negedge i_mclk);
        fclr = 4'h0;
        @(negedge i_mclk);
        chk("cleared", 32'h0, {28'h0, w_flag});
    endtask
    task automatic t_compare();
        logic o;
        mode = 8'hB1;
        cfg(16'h0, 32'h3, 1'b0, gptf_pkg::GPTF_SM_FREE);
        wait_upd(1'b0);
        o = w_out[0];
        wait_upd(1'b0);
        chk("toggle", {31'h0, ~o}, {31'h0, w_out[0]});
        chk("match_flag", 32'hD, {28'h0, w_flag});
        chk("pulse_low", 32'h0, {31'h0, w_out[2]});
        n = 0;
        repeat (8) begin
            @(negedge i_mclk);
            n += w_out[3];
        end
        chk("pwm_high", 32'h4, n);
    endtask
    task automatic t_encoder();
        logic [31:0] d;
        cfg(16'h0, 32'h3E8, 1'b0, gptf_pkg::GPTF_SM_FREE);
        repeat (50) @(negedge i_mclk);
        sm = gptf_pkg::GPTF_SM_ENCODER;
        repeat (3) @(negedge i_mclk);
        s = w_cnt;
        repeat (4) gptf_pins_model_inst.enc_step(1'b1);
        d = w_cnt - s;
        chk("enc_fwd", 32'h4, d);
        repeat (4) gptf_pins_model_inst.enc_step(1'b0);
        chk("enc_back", s, w_cnt);
    endtask
    task automatic t_slave();
        cfg(16'h0, 32'h3E8, 1'b0, gptf_pkg::GPTF_SM_RESET);
        repeat (50) @(negedge i_mclk);
        gptf_pins_model_inst.trig_pulse();
        chk("trig_reset", 32'h0, w_cnt);
        chk("red_follow", 32'h0, {16'h0, r_cnt});
        gptf_pins_model_inst.hall_flip();
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (w_hev !== 1'b1 && n < 8);
        chk("hall_event", 32'h1, {31'h0, w_hev});
    endtask
    // Main sequence after a three-cycle reset.
    initial begin
        i_srst = 1'b1;
        en = 1'b0;
        dn = 1'b0;
        halt = 1'b0;
        frz = 1'b0;
        sm = 2'h0;
        psc = 16'h0;
        arr = 32'h0;
        mode = 8'h00;
        cmp = {32'h2, 32'h3, 32'h0, 32'h1};
        fclr = 4'h0;
        repeat (3) @(posedge i_mclk);
        t_period(16'h0, 32'h2, 1'b0);
        t_period(16'h2, 32'h3, 1'b0);
        t_period(16'h1, 32'h4, 1'b1);
        t_freeze();
        t_capture();
        t_compare();
        t_encoder();
        t_slave();
        results();
    end
endmodule // general_purpose_timer_family_tb
